// file: src/smfl_regs.svh
// Register map, field positions, reset values and timing figures of the drive supervisor.
// Assumes byte addresses on an 8-bit register port with 32-bit data words.
`ifndef SMFL_REGS_SVH
`define SMFL_REGS_SVH
// ==========================================================
// Offsets
`define SMFL_A_CFG 8'h00
`define SMFL_A_RES1 8'h04
`define SMFL_A_RES2 8'h08
`define SMFL_A_RES3 8'h0c
`define SMFL_A_PMODE 8'h10
`define SMFL_A_PVEL 8'h14
`define SMFL_A_PDIST 8'h18
`define SMFL_A_PREP 8'h1c
`define SMFL_A_PCMD 8'h20
`define SMFL_A_FCMD 8'h24
`define SMFL_A_FSTAT 8'h28
`define SMFL_A_FHIST 8'h2c
// ==========================================================
// Command bits
`define SMFL_B_START 0
`define SMFL_B_STOP 1
`define SMFL_B_CLR_CUR 0
`define SMFL_B_CLR_ALL 1
// ==========================================================
// Reset values
`define SMFL_RST_CFG 4'hc
`define SMFL_RST_RES12 32'h0000_0000
`define SMFL_RST_RES3 32'h0080_0080
`define SMFL_RST_PMODE 2'h0
`define SMFL_RST_PVEL 32'h0000_2710
`define SMFL_RST_PDIST 32'h0c80_0001
`define SMFL_RST_PREP 32'h0064_0001
// ==========================================================
// Sizes and timing
`define SMFL_HIST_N 10
`define SMFL_MS_NS 1000000
`define SMFL_CLK_NS 10
`endif

// file: src/smfl_pkg.sv
// Types used by the drive supervisor.
// Assumes nothing beyond a SystemVerilog compiler.
package smfl_pkg;
  // ==========================================================
  // Fault codes in the history
  typedef enum logic [1:0] {
    FLT_NONE = 2'h0,
    FLT_CURRENT = 2'h1,
    FLT_SUPPLY = 2'h2,
    FLT_WIRING = 2'h3
  } smfl_fault_type;
  // ==========================================================
  // Test pulser states, one-hot
  typedef enum logic [2:0] {
    PG_IDLE = 3'h1,
    PG_MOVE = 3'h2,
    PG_PAUSE = 3'h4
  } smfl_state_type;
  // ==========================================================
  // Register layouts
  typedef struct packed {
    logic wiring_detect;
    logic alarm_high;
    logic alarm_clear_by_enable;
    logic enable_polarity_select;
  } smfl_cfg_type;
  typedef struct packed {
    logic [15:0] phase;
    logic [15:0] amplitude;
  } smfl_res_type;
  typedef struct packed {
    logic bidirectional;
    logic positive;
  } smfl_pmode_type;
  typedef struct packed {
    logic wiring;
    logic supply;
    logic current;
  } smfl_faults_type;
endpackage

// file: src/smfl_top.sv
// Drive supervisor: enable/alarm options, anti-resonance set, test pulser, fault log.
// Assumes a single 100 MHz clock and detector flags already synchronous to it.
//
// How it works
// - With clear-by-enable set, any enable input change clears active faults.
// - A config bit selects active-low or active-high enable input.
// - Anti-resonance runs unless every amplitude and phase value is zero.
// - Three amplitude/phase areas; area two resets to zero, area three to 128.
// - Bidirectional mode alternates direction, otherwise pulser runs one way.
// - Pulser starts in the configured initial direction.
// - Pulser idles a programmed number of milliseconds between repeats.
// - Pulser runs programmed repeats; bidirectional repeat is forward then back.
// - Each one-way move covers programmed revolutions times steps per revolution.
// - Host start command begins motion, stop command halts it.
// - Velocity setting is sampled only at start and when direction changes.
// - Status shows active faults and the recorded history.
// - Clear-current command drops active faults and keeps history.
// - Clear-all command drops active faults and the whole history.
// - History holds ten faults, entry 0 newest, entry 9 oldest.
// - Over-current flag latches the current limit fault.
// - Over-voltage flag (about 90 V) latches the supply fault.
// - Wiring flag latches the motor wiring fault.
// - A config bit selects active-high or active-low alarm output.
// - Wiring faults count only while wiring detection is enabled.
`timescale 1ns/100ps
`include "smfl_regs.svh"
module smfl_top #(
  parameter int MS_CYCLES = `SMFL_MS_NS / `SMFL_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic drive_enable_input,
  input wire logic current_limit_fault,
  input wire logic supply_high_fault,
  input wire logic motor_wiring_fault,
  output logic drive_enabled,
  output logic alarm_out,
  output logic anti_res_enable,
  output logic test_step,
  output logic test_dir,
  output logic test_busy
);
  // ==========================================================
  // Registers
  smfl_pkg::smfl_cfg_type cfg_r;
  smfl_pkg::smfl_res_type res1_r, res2_r, res3_r;
  smfl_pkg::smfl_pmode_type pmode_r;
  logic [31:0] pvel_r, pdist_r, prep_r;
  logic wr_cmd, wr_fcmd, start_cmd, stop_cmd, clr_cur, clr_all;

  assign wr_cmd = reg_wr && (reg_addr == `SMFL_A_PCMD);
  assign wr_fcmd = reg_wr && (reg_addr == `SMFL_A_FCMD);
  assign start_cmd = wr_cmd && reg_wdata[`SMFL_B_START];
  assign stop_cmd = wr_cmd && reg_wdata[`SMFL_B_STOP];
  assign clr_cur = wr_fcmd && reg_wdata[`SMFL_B_CLR_CUR];
  assign clr_all = wr_fcmd && reg_wdata[`SMFL_B_CLR_ALL];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= `SMFL_RST_CFG;
      res1_r <= `SMFL_RST_RES12;
      res2_r <= `SMFL_RST_RES12;
      res3_r <= `SMFL_RST_RES3;
      pmode_r <= `SMFL_RST_PMODE;
      pvel_r <= `SMFL_RST_PVEL;
      pdist_r <= `SMFL_RST_PDIST;
      prep_r <= `SMFL_RST_PREP;
    end else if (reg_wr) begin
      case (reg_addr)
        `SMFL_A_CFG: cfg_r <= smfl_pkg::smfl_cfg_type'(reg_wdata[3:0]);
        `SMFL_A_RES1: res1_r <= reg_wdata;
        `SMFL_A_RES2: res2_r <= reg_wdata;
        `SMFL_A_RES3: res3_r <= reg_wdata;
        `SMFL_A_PMODE: pmode_r <= smfl_pkg::smfl_pmode_type'(reg_wdata[1:0]);
        `SMFL_A_PVEL: pvel_r <= reg_wdata;
        `SMFL_A_PDIST: pdist_r <= reg_wdata;
        `SMFL_A_PREP: prep_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Enable input, alarm and anti-resonance outputs
  logic ena_prev_r;
  logic ena_edge;
  smfl_pkg::smfl_faults_type active_r;

  assign ena_edge = drive_enable_input != ena_prev_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ena_prev_r <= 1'b0;
      drive_enabled <= 1'b0;
      alarm_out <= 1'b0;
      anti_res_enable <= 1'b0;
    end else begin
      ena_prev_r <= drive_enable_input;
      drive_enabled <= drive_enable_input ^ cfg_r.enable_polarity_select;
      alarm_out <= (|active_r) ~^ cfg_r.alarm_high;
      anti_res_enable <= |{res1_r, res2_r, res3_r};
    end
  end

  a_enable_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1 |=> drive_enabled == ($past(drive_enable_input) ^ $past(cfg_r.enable_polarity_select)))
    else $error("enable level wrong");
  a_alarm_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (active_r != 0) ##1 (active_r != 0) |-> alarm_out == cfg_r.alarm_high)
    else $error("alarm level wrong");
  a_antires_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ({res1_r, res2_r, res3_r} == 0) [*2] |-> !anti_res_enable)
    else $error("anti-resonance on with zero set");

  // ==========================================================
  // Fault latch
  // Set beats every clear so a fault arriving with a clear is never lost.
  smfl_pkg::smfl_faults_type flt_in, flt_new;
  logic clr_active;

  assign flt_in = '{wiring: motor_wiring_fault && cfg_r.wiring_detect,
                    supply: supply_high_fault,
                    current: current_limit_fault};
  assign flt_new = flt_in & ~active_r;
  assign clr_active = clr_cur || clr_all || (ena_edge && cfg_r.alarm_clear_by_enable);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_r <= '0;
    end else if (clr_active) begin
      active_r <= flt_in;
    end else begin
      active_r <= active_r | flt_in;
    end
  end

  a_ena_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ena_edge && cfg_r.alarm_clear_by_enable && flt_in == 0) |=> active_r == 0)
    else $error("enable edge did not clear");
  // New faults may still join, so only the loss of an active bit counts here
  a_ena_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (active_r != 0 && !cfg_r.alarm_clear_by_enable && !clr_cur && !clr_all)
    |=> (active_r & $past(active_r)) == $past(active_r))
    else $error("fault cleared without a clear");
  a_wiring_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!active_r.wiring && !cfg_r.wiring_detect) |=> !active_r.wiring)
    else $error("wiring fault while detection off");
  a_fault_latch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    supply_high_fault |=> active_r.supply)
    else $error("supply fault not latched");
  a_current_latch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    current_limit_fault |=> active_r.current)
    else $error("current fault not latched");
  a_wiring_latch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (motor_wiring_fault && cfg_r.wiring_detect) |=> active_r.wiring)
    else $error("wiring fault not latched");

  // ==========================================================
  // Fault history, entry 0 newest
  // Only one push per cycle: with simultaneous new faults the lowest code is logged.
  smfl_pkg::smfl_fault_type hist_r [`SMFL_HIST_N];
  smfl_pkg::smfl_fault_type new_code;
  logic [2*`SMFL_HIST_N-1:0] hist_flat;

  always_comb begin
    new_code = smfl_pkg::FLT_NONE;
    if (flt_new.current) begin
      new_code = smfl_pkg::FLT_CURRENT;
    end else if (flt_new.supply) begin
      new_code = smfl_pkg::FLT_SUPPLY;
    end else if (flt_new.wiring) begin
      new_code = smfl_pkg::FLT_WIRING;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SMFL_HIST_N; gi++) begin : g_hist
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          hist_r[gi] <= smfl_pkg::FLT_NONE;
        end else if (new_code != smfl_pkg::FLT_NONE) begin
          if (gi == 0) begin
            hist_r[gi] <= new_code;
          end else if (clr_all) begin
            hist_r[gi] <= smfl_pkg::FLT_NONE;
          end else begin
            hist_r[gi] <= hist_r[(gi == 0) ? 0 : gi - 1];
          end
        end else if (clr_all) begin
          hist_r[gi] <= smfl_pkg::FLT_NONE;
        end
      end
      assign hist_flat[2*gi +: 2] = hist_r[gi];
    end
  endgenerate

  a_hist_push: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (new_code != smfl_pkg::FLT_NONE && !clr_all)
    |=> hist_r[0] == $past(new_code) && hist_r[9] == $past(hist_r[8]))
    else $error("history push wrong");
  a_clear_all: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clr_all && flt_in == 0) |=> hist_flat == 0 && active_r == 0)
    else $error("clear all incomplete");
  a_clear_cur: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clr_cur && !clr_all && flt_in == 0) |=> active_r == 0 && hist_flat == $past(hist_flat))
    else $error("clear current wrong");

  // ==========================================================
  // Test pulser
  smfl_pkg::smfl_state_type st_r;
  logic [31:0] total_steps, steps_left_r, period_r, per_cnt_r, tick_r;
  logic [15:0] reps_left_r, ms_left_r;
  logic leg_r;

  assign total_steps = {16'h0000, pdist_r[15:0]} * {16'h0000, pdist_r[31:16]};
  assign test_busy = st_r != smfl_pkg::PG_IDLE;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= smfl_pkg::PG_IDLE;
      steps_left_r <= '0;
      period_r <= '0;
      per_cnt_r <= '0;
      tick_r <= '0;
      reps_left_r <= '0;
      ms_left_r <= '0;
      leg_r <= 1'b0;
      test_dir <= 1'b0;
      test_step <= 1'b0;
    end else begin
      test_step <= 1'b0;
      if (stop_cmd) begin
        st_r <= smfl_pkg::PG_IDLE;
      end else begin
        case (st_r)
          smfl_pkg::PG_IDLE: begin
            if (start_cmd && prep_r[15:0] != 0 && total_steps != 0) begin
              st_r <= smfl_pkg::PG_MOVE;
              test_dir <= pmode_r.positive;
              period_r <= pvel_r;
              per_cnt_r <= '0;
              steps_left_r <= total_steps;
              reps_left_r <= prep_r[15:0];
              leg_r <= 1'b0;
            end
          end
          smfl_pkg::PG_MOVE: begin
            if (steps_left_r == 32'h0) begin
              // Leg ends a cycle after its last step, so direction never moves with a step
              per_cnt_r <= '0;
              if (pmode_r.bidirectional && !leg_r) begin
                leg_r <= 1'b1;
                test_dir <= ~test_dir;
                period_r <= pvel_r;
                steps_left_r <= total_steps;
              end else if (reps_left_r == 16'h1) begin
                st_r <= smfl_pkg::PG_IDLE;
              end else begin
                reps_left_r <= reps_left_r - 16'h1;
                ms_left_r <= prep_r[31:16];
                tick_r <= '0;
                st_r <= smfl_pkg::PG_PAUSE;
              end
            end else if (per_cnt_r + 32'h1 >= period_r) begin
              per_cnt_r <= '0;
              test_step <= 1'b1;
              steps_left_r <= steps_left_r - 32'h1;
            end else begin
              per_cnt_r <= per_cnt_r + 32'h1;
            end
          end
          smfl_pkg::PG_PAUSE: begin
            if (ms_left_r == 16'h0) begin
              st_r <= smfl_pkg::PG_MOVE;
              steps_left_r <= total_steps;
              per_cnt_r <= '0;
              leg_r <= 1'b0;
              if (pmode_r.bidirectional) begin
                test_dir <= pmode_r.positive;
                period_r <= pvel_r;
              end
            end else if (tick_r + 32'h1 >= MS_CYCLES) begin
              tick_r <= '0;
              ms_left_r <= ms_left_r - 16'h1;
            end else begin
              tick_r <= tick_r + 32'h1;
            end
          end
          default: st_r <= smfl_pkg::PG_IDLE;
        endcase
      end
    end
  end

  a_stop_halts: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stop_cmd |=> !test_busy ##1 !test_step)
    else $error("stop did not halt");
  a_start_dir: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (start_cmd && !stop_cmd && !test_busy && prep_r[15:0] != 0 && total_steps != 0)
    |=> test_busy && test_dir == $past(pmode_r.positive))
    else $error("start direction wrong");
  a_dir_bidir: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (test_busy && $past(test_busy) && test_dir != $past(test_dir)) |-> $past(pmode_r.bidirectional))
    else $error("direction flip in one-way mode");
  a_vel_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (test_busy && $past(test_busy) && test_dir == $past(test_dir)) |-> period_r == $past(period_r))
    else $error("velocity changed without reversal");
  a_pause_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == smfl_pkg::PG_PAUSE) |-> !test_step)
    else $error("step during pause");

  // ==========================================================
  // Read port, data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `SMFL_A_CFG: reg_rdata <= {28'h0, cfg_r};
        `SMFL_A_RES1: reg_rdata <= res1_r;
        `SMFL_A_RES2: reg_rdata <= res2_r;
        `SMFL_A_RES3: reg_rdata <= res3_r;
        `SMFL_A_PMODE: reg_rdata <= {30'h0, pmode_r};
        `SMFL_A_PVEL: reg_rdata <= pvel_r;
        `SMFL_A_PDIST: reg_rdata <= pdist_r;
        `SMFL_A_PREP: reg_rdata <= prep_r;
        `SMFL_A_PCMD: reg_rdata <= {reps_left_r, 5'h0, st_r, 6'h0, test_dir, test_busy};
        `SMFL_A_FSTAT: reg_rdata <= {27'h0, anti_res_enable, alarm_out, active_r};
        `SMFL_A_FHIST: reg_rdata <= {12'h0, hist_flat};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// file: bench/smfl_host_model.sv
// Tuning host model: master of the register port, issuing parameter writes and commands.
// Assumes the slave answers a read in the following cycle and never makes the host wait.
`timescale 1ns/100ps
`include "smfl_regs.svh"
module smfl_host_model (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // ==========================================================
  // Bus cycles
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Lines between cycles are inverted so a stale value cannot pass for a live one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
  // ==========================================================
  // Commands
  task automatic start_run();
    wr(`SMFL_A_PCMD, 32'h0000_0001);
  endtask
  task automatic stop_run();
    wr(`SMFL_A_PCMD, 32'h0000_0002);
  endtask
  task automatic clear_current();
    wr(`SMFL_A_FCMD, 32'h0000_0001);
  endtask
  task automatic clear_all();
    wr(`SMFL_A_FCMD, 32'h0000_0002);
  endtask
endmodule

// file: bench/smfl_top_tb.sv
// Self-checking bench of the drive supervisor, driven through the tuning host model.
// Assumes a short millisecond count so that pulser pauses stay brief.
`timescale 1ns/100ps
`include "smfl_regs.svh"
module smfl_top_tb;
  localparam int MS = 10;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic drive_enable_input = 1'b0;
  logic [2:0] flg = 3'h0;
  logic drive_enabled;
  logic alarm_out;
  logic anti_res_enable;
  logic test_step;
  logic test_dir;
  logic test_busy;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_step = 0;
  int st_t[64];
  logic st_d[64];
  logic [31:0] d;
  logic [31:0] e;
  always #5 ref_clk = ~ref_clk;
  smfl_top #(.MS_CYCLES(MS)) smfl_top_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drive_enable_input(drive_enable_input), .current_limit_fault(flg[0]),
    .supply_high_fault(flg[1]), .motor_wiring_fault(flg[2]), .drive_enabled(drive_enabled),
    .alarm_out(alarm_out), .anti_res_enable(anti_res_enable), .test_step(test_step),
    .test_dir(test_dir), .test_busy(test_busy));
  smfl_host_model smfl_host_model_inst (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ==========================================================
  // Step monitor
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (test_step === 1'b1 && n_step < 64) begin
      st_t[n_step] = cyc;
      st_d[n_step] = test_dir;
      n_step = n_step + 1;
    end
  end
  // ==========================================================
  // Helpers
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    smfl_host_model_inst.rd(a, d);
    chk(d, exp);
  endtask
  task automatic fchk(input logic [31:0] act, input logic [31:0] hist);
    smfl_host_model_inst.rd(`SMFL_A_FSTAT, d);
    chk(d & 32'h7, act);
    rchk(`SMFL_A_FHIST, hist);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge ref_clk);
    flg <= m;
    @(posedge ref_clk);
    flg <= 3'h0;
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // Bounded wait for the pulser to go idle; a hang ends the run
  task automatic wait_idle(input int bound);
    int i;
    for (i = 0; i < bound && test_busy !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (test_busy !== 1'b0) begin
      $display("unexpected at %0t: pulser never went idle", $time);
      n_mismatch++;
      close_out();
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rchk(`SMFL_A_CFG, 32'h0000_000c);
    rchk(`SMFL_A_RES2, 32'h0000_0000);
    rchk(`SMFL_A_RES3, 32'h0080_0080);
    rchk(8'h30, 32'h0000_0000);
    chk(anti_res_enable, 1'b1);
    smfl_host_model_inst.wr(`SMFL_A_RES3, 32'h0000_0000);
    settle();
    chk(anti_res_enable, 1'b0);
    smfl_host_model_inst.wr(`SMFL_A_RES1, 32'h0001_0000);
    settle();
    chk(anti_res_enable, 1'b1);
    smfl_host_model_inst.wr(`SMFL_A_RES1, 32'h0000_0000);
    smfl_host_model_inst.wr(`SMFL_A_RES2, 32'h0000_0001);
    settle();
    chk(anti_res_enable, 1'b1);
    // Fault detection, logging and clearing
    pulse(3'h2);
    rchk(`SMFL_A_FSTAT, 32'h0000_001a);
    rchk(`SMFL_A_FHIST, 32'h0000_0002);
    chk(alarm_out, 1'b1);
    pulse(3'h1);
    fchk(32'h3, 32'h9);
    pulse(3'h4);
    fchk(32'h7, 32'h27);
    smfl_host_model_inst.clear_current();
    fchk(32'h0, 32'h27);
    settle();
    chk(alarm_out, 1'b0);
    smfl_host_model_inst.wr(`SMFL_A_CFG, 32'h0000_0004);
    pulse(3'h4);
    fchk(32'h0, 32'h27);
    smfl_host_model_inst.wr(`SMFL_A_CFG, 32'h0000_0008);
    settle();
    chk(alarm_out, 1'b1);
    smfl_host_model_inst.clear_all();
    fchk(32'h0, 32'h0);
    // Eleven pushes: the first one must fall off the end
    smfl_host_model_inst.wr(`SMFL_A_CFG, 32'h0000_000c);
    e = 32'h0;
    for (int i = 0; i < 11; i++) begin
      pulse((i % 2) ? 3'h2 : 3'h1);
      smfl_host_model_inst.clear_current();
      e = ((e << 2) | ((i % 2) ? 32'h2 : 32'h1)) & 32'h000f_ffff;
    end
    fchk(32'h0, e);
    // Alarm clear by enable transition, on and off
    smfl_host_model_inst.wr(`SMFL_A_CFG, 32'h0000_000e);
    pulse(3'h2);
    @(posedge ref_clk);
    drive_enable_input <= 1'b1;
    fchk(32'h0, (e << 2 | 32'h2) & 32'h000f_ffff);
    smfl_host_model_inst.wr(`SMFL_A_CFG, 32'h0000_000c);
    pulse(3'h2);
    @(posedge ref_clk);
    drive_enable_input <= 1'b0;
    smfl_host_model_inst.rd(`SMFL_A_FSTAT, d);
    chk(d & 32'h7, 32'h2);
    smfl_host_model_inst.clear_current();
    // Enable polarity
    settle();
    chk(drive_enabled, 1'b0);
    @(posedge ref_clk);
    drive_enable_input <= 1'b1;
    settle();
    chk(drive_enabled, 1'b1);
    smfl_host_model_inst.wr(`SMFL_A_CFG, 32'h0000_000d);
    settle();
    chk(drive_enabled, 1'b0);
    // Bidirectional pulser: 2 repeats of 3 steps each way, pause 1 ms
    smfl_host_model_inst.wr(`SMFL_A_PVEL, 32'h0000_0002);
    smfl_host_model_inst.wr(`SMFL_A_PDIST, 32'h0003_0001);
    smfl_host_model_inst.wr(`SMFL_A_PREP, 32'h0001_0002);
    smfl_host_model_inst.wr(`SMFL_A_PMODE, 32'h0000_0003);
    n_step = 0;
    smfl_host_model_inst.start_run();
    #1;
    chk({test_busy, test_dir}, 2'h3);
    smfl_host_model_inst.wr(`SMFL_A_PVEL, 32'h0000_0006);
    wait_idle(2000);
    chk(n_step, 12);
    for (int i = 0; i < 12; i++) begin
      chk(st_d[i], ((i / 3) % 2) ? 1'b0 : 1'b1);
    end
    chk((st_t[1] - st_t[0]) < (st_t[4] - st_t[3]), 1'b1);
    chk((st_t[6] - st_t[5]) > MS, 1'b1);
    // One-way pulser, negative start: all six steps keep one direction
    smfl_host_model_inst.wr(`SMFL_A_PMODE, 32'h0000_0000);
    n_step = 0;
    smfl_host_model_inst.start_run();
    #1;
    chk({test_busy, test_dir}, 2'h2);
    wait_idle(2000);
    chk(n_step, 6);
    for (int i = 0; i < 6; i++) begin
      chk(st_d[i], 1'b0);
    end
    // Stop in mid-run
    smfl_host_model_inst.wr(`SMFL_A_PREP, 32'h0001_0064);
    smfl_host_model_inst.start_run();
    repeat (5) @(posedge ref_clk);
    smfl_host_model_inst.stop_run();
    wait_idle(3);
    close_out();
  end
endmodule
